// ===== core/utp_core.sv
// resistor enable decode, power-on reset and bus ownership handshake
`timescale 1ns/1ns
// Notes on behaviour
// - resistor enables follow select, termination, mode and pull-down request bits
// - host test J/K: both pull-downs plus fast termination, no pull-up
// - peripheral test J/K: only fast termination enabled
// - fixed power-on pulse at trip; short dips ignored, long dips retrigger
// - dir high from power-up until the pll is stable
// - while dir is high, nxt low and status driven on data
// - reset bit holds dir high for the reset, then self-clears
// - one status byte follows every completed soft reset
// - interface clock runs once pll is stable and dir falls
// - enables drive 1.5k pull-up, 15k pull-downs, 45 ohm terminations
module utp_core
    import utp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // analog side
    input wire logic core_supply_node_i,
    input wire logic pll_locked_i,
    input wire logic [1:0] line_state_i,
    output logic dp_pullup_enable_o,
    output logic dp_weak_low_enable_o,
    output logic dm_weak_low_enable_o,
    output logic fast_termination_enable_o,
    // ulpi side
    output logic dir_o,
    output logic nxt_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    input wire logic [7:0] data_i,
    output logic clk_run_o
);

    function automatic logic [3:0] decode(input logic [1:0] xs, input logic ts,
                                          input logic [1:0] om, input logic dpr,
                                          input logic dmr);
        logic [3:0] r;
        r = 4'h0;
        if (om != OM_NODRIVE) begin
            r[RES_PU] = ts & ~dpr;
            r[RES_DPD] = dpr;
            r[RES_DMD] = dmr;
            r[RES_TERM] = (xs == 2'h0) & ~ts;
        end
        return r;
    endfunction

    // register group
    logic [1:0] transceiver_select_q, transceiver_select_d;
    logic termination_select_q, termination_select_d;
    logic [1:0] line_operating_mode_q, line_operating_mode_d;
    logic dp_low_side_request_q, dp_low_side_request_d;
    logic dm_low_side_request_q, dm_low_side_request_d;
    logic soft_rst_q, soft_rst_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [3:0] res_q, res_d;
    // power-on group
    logic [7:0] hi_cnt_q, hi_cnt_d, lo_cnt_q, lo_cnt_d, porp_cnt_q, porp_cnt_d;
    logic armed_q, armed_d;
    logic por_fire, por_act;
    // sequencing group
    utp_state_t state_q, state_d;
    logic [7:0] rst_cnt_q, rst_cnt_d;
    logic dir_q, dir_d, clk_q, clk_d;
    logic [7:0] data_q, data_d;
    logic rst_done;

    assign por_act = porp_cnt_q != 8'h00;
    assign rst_done = state_q == ST_RST && rst_cnt_q == 8'h01;

    always_comb begin
        hi_cnt_d = core_supply_node_i ? hi_cnt_q : 8'h00;
        lo_cnt_d = core_supply_node_i ? 8'h00 : lo_cnt_q;
        armed_d = armed_q;
        porp_cnt_d = por_act ? porp_cnt_q - 8'h01 : porp_cnt_q;
        por_fire = 1'b0;
        if (core_supply_node_i && hi_cnt_q != HI_CYC) begin
            hi_cnt_d = hi_cnt_q + 8'h01;
        end
        if (!core_supply_node_i && lo_cnt_q != LO_CYC) begin
            lo_cnt_d = lo_cnt_q + 8'h01;
        end
        // only a dip of full low width re-arms; shorter glitches pass unseen
        if (!core_supply_node_i && lo_cnt_q == LO_CYC) begin
            armed_d = 1'b1;
        end
        if (armed_q && hi_cnt_q == HI_CYC) begin
            por_fire = 1'b1;
            armed_d = 1'b0;
            porp_cnt_d = PORP_CYC;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            hi_cnt_q <= 8'h00;
            lo_cnt_q <= 8'h00;
            armed_q <= 1'b1;
            porp_cnt_q <= 8'h00;
        end else if (ce_i) begin
            hi_cnt_q <= hi_cnt_d;
            lo_cnt_q <= lo_cnt_d;
            armed_q <= armed_d;
            porp_cnt_q <= porp_cnt_d;
        end
    end

    // registers and bus
    always_comb begin
        logic hit, wr;
        hit = wb_cyc_i & wb_stb_i & ~ack_q;
        wr = hit & wb_we_i & wb_sel_i[0];
        transceiver_select_d = transceiver_select_q;
        termination_select_d = termination_select_q;
        line_operating_mode_d = line_operating_mode_q;
        dp_low_side_request_d = dp_low_side_request_q;
        dm_low_side_request_d = dm_low_side_request_q;
        soft_rst_d = soft_rst_q;
        // self-clear on completion, registers back to defaults
        if (rst_done || por_act) begin
            transceiver_select_d = XS_RST;
            termination_select_d = TS_RST;
            line_operating_mode_d = OM_RST;
            dp_low_side_request_d = DP_RST;
            dm_low_side_request_d = DM_RST;
            soft_rst_d = 1'b0;
        end
        // a fresh write wins over the completion clear so it is not lost
        if (wr && wb_adr_i == ADR_FUNC) begin
            transceiver_select_d = wb_dat_i[FN_XS_LSB +: 2];
            termination_select_d = wb_dat_i[FN_TS];
            line_operating_mode_d = wb_dat_i[FN_OM_LSB +: 2];
            soft_rst_d = wb_dat_i[FN_RST] | (soft_rst_q & ~rst_done);
        end
        if (wr && wb_adr_i == ADR_OTG) begin
            dp_low_side_request_d = wb_dat_i[OTG_DP];
            dm_low_side_request_d = wb_dat_i[OTG_DM];
        end
        ack_d = hit;
        rdat_d = 32'h0;
        case (wb_adr_i)
            ADR_FUNC: begin
                rdat_d[FN_XS_LSB +: 2] = transceiver_select_q;
                rdat_d[FN_TS] = termination_select_q;
                rdat_d[FN_OM_LSB +: 2] = line_operating_mode_q;
                rdat_d[FN_RST] = soft_rst_q;
            end
            ADR_OTG: begin
                rdat_d[OTG_DP] = dp_low_side_request_q;
                rdat_d[OTG_DM] = dm_low_side_request_q;
            end
            ADR_STAT: begin
                rdat_d[ST_RES_LSB +: 4] = res_q;
                rdat_d[ST_DIR] = dir_q;
                rdat_d[ST_CLK] = clk_q;
            end
            default: rdat_d = 32'h0;
        endcase
        if (!hit) begin
            rdat_d = 32'h0;
        end
        // enables recomputed from the next register settings, so they update in the same cycle as the stored ones
        res_d = decode(transceiver_select_d, termination_select_d, line_operating_mode_d,
                       dp_low_side_request_d, dm_low_side_request_d);
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            transceiver_select_q <= XS_RST;
            termination_select_q <= TS_RST;
            line_operating_mode_q <= OM_RST;
            dp_low_side_request_q <= DP_RST;
            dm_low_side_request_q <= DM_RST;
            soft_rst_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            res_q <= RES_POWERUP;
        end else if (ce_i) begin
            transceiver_select_q <= transceiver_select_d;
            termination_select_q <= termination_select_d;
            line_operating_mode_q <= line_operating_mode_d;
            dp_low_side_request_q <= dp_low_side_request_d;
            dm_low_side_request_q <= dm_low_side_request_d;
            soft_rst_q <= soft_rst_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            res_q <= res_d;
        end
    end

    // bus ownership sequencing
    always_comb begin
        state_d = state_q;
        rst_cnt_d = rst_cnt_q;
        clk_d = clk_q;
        case (state_q)
            // bus unusable until the pll settles
            ST_POR: begin
                if (porp_cnt_q == 8'h01) begin
                    state_d = ST_PLL;
                end
            end
            ST_PLL: begin
                if (pll_locked_i) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (soft_rst_q) begin
                    state_d = ST_RST;
                    rst_cnt_d = SRST_CYC;
                end
            end
            // dir stays high for the whole soft reset
            ST_RST: begin
                rst_cnt_d = rst_cnt_q - 8'h01;
                if (rst_done) begin
                    state_d = ST_RXCMD;
                end
            end
            // single status byte, then the bus goes back to the link
            ST_RXCMD: state_d = ST_IDLE;
            default: state_d = ST_POR;
        endcase
        if (por_fire || por_act) begin
            state_d = por_fire || porp_cnt_q != 8'h01 ? ST_POR : ST_PLL;
        end
        // clock starts with the first release of dir
        if (state_d == ST_IDLE && state_q == ST_PLL) begin
            clk_d = 1'b1;
        end
        if (state_d == ST_POR) begin
            clk_d = 1'b0;
        end
        dir_d = state_d != ST_IDLE;
        // status on the bus whenever dir is high
        data_d = dir_d ? {6'h00, line_state_i} : 8'h00;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q <= ST_POR;
            rst_cnt_q <= 8'h00;
            dir_q <= 1'b1;
            clk_q <= 1'b0;
            data_q <= 8'h00;
        end else if (ce_i) begin
            state_q <= state_d;
            rst_cnt_q <= rst_cnt_d;
            dir_q <= dir_d;
            clk_q <= clk_d;
            data_q <= data_d;
        end
    end

    // the transmit path is not part of this block, so nxt never rises
    assign nxt_o = 1'b0;
    assign dir_o = dir_q;
    assign data_o = data_q;
    assign data_oe_o = dir_q;
    assign clk_run_o = clk_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign dp_pullup_enable_o = res_q[RES_PU];
    assign dp_weak_low_enable_o = res_q[RES_DPD];
    assign dm_weak_low_enable_o = res_q[RES_DMD];
    assign fast_termination_enable_o = res_q[RES_TERM];

    // remaining pulse cycles after the first eight, up to the first cycle with the pulse gone
    localparam int POR_TAIL = int'(PORP_CYC) - 7;
    logic host_tst, per_tst, otg_tst, tst_base;
    assign tst_base = transceiver_select_q == 2'h0 && !termination_select_q
                      && line_operating_mode_q == 2'h2;
    assign host_tst = tst_base && dp_low_side_request_q && dm_low_side_request_q;
    assign per_tst = tst_base && !dp_low_side_request_q && !dm_low_side_request_q;
    assign otg_tst = tst_base && !dp_low_side_request_q && dm_low_side_request_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i || !ce_i);

    decode_match_a: assert property (
        ##1 res_q == $past(res_d)) else $error("resistor enables differ from decode");
    host_test_a: assert property (
        host_tst |-> res_q == 4'h7) else $error("host test enables wrong");
    periph_test_a: assert property (
        per_tst |-> res_q == 4'h1) else $error("peripheral test enables wrong");
    otg_test_a: assert property (
        otg_tst |-> res_q == 4'h3) else $error("otg test enables wrong");
    por_len_a: assert property (
        por_fire |=> por_act[*8] ##POR_TAIL !por_act) else $error("por pulse length wrong");
    pll_dir_a: assert property (
        state_q == ST_PLL && !pll_locked_i |=> dir_o) else $error("dir low before pll lock");
    nxt_data_a: assert property (
        dir_o |-> !nxt_o && data_oe_o && data_o[7:2] == 6'h00) else $error("bus not held by dir");
    rst_dir_a: assert property (
        state_q == ST_RST || state_q == ST_RXCMD |-> dir_o)
        else $error("dir fell during soft reset");
    rst_entry_a: assert property (
        soft_rst_q && state_q == ST_IDLE && !por_act && !por_fire |=> state_q == ST_RST && dir_o)
        else $error("soft reset not started");
    rst_clear_a: assert property (
        rst_done && !por_act && !por_fire |=> !soft_rst_q || $past(ack_d && wb_we_i))
        else $error("reset bit not cleared");
    rxcmd_once_a: assert property (
        rst_done && !por_fire |=> state_q == ST_RXCMD && dir_o ##1 !dir_o || por_act)
        else $error("status byte not sent once");
    clk_start_a: assert property (
        $rose(clk_run_o) |-> !dir_o && $past(state_q) == ST_PLL) else $error("clock start wrong");

    soft_reset_c: cover property (rst_done ##1 state_q == ST_RXCMD ##1 !dir_o);
    por_again_c: cover property (por_fire ##[1:1000] clk_run_o ##[1:1000] por_fire);
    host_test_c: cover property (host_tst && fast_termination_enable_o);

endmodule

// ===== core/utp_pkg.sv
// shared constants and types for the termination and power-up block
package utp_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_W_HIGH_NS = 1000;
    localparam int T_W_LOW_NS = 500;
    localparam int T_PORP_NS = 2000;
    localparam int T_SOFT_RST_NS = 500;
    localparam int CNT_W = 8;
    localparam logic [7:0] HI_CYC = 8'((T_W_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] LO_CYC = 8'((T_W_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] PORP_CYC = 8'((T_PORP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SRST_CYC = 8'((T_SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ADR_FUNC = 8'h00;
    localparam logic [7:0] ADR_OTG = 8'h04;
    localparam logic [7:0] ADR_STAT = 8'h08;
    localparam int FN_XS_LSB = 0;
    localparam int FN_TS = 2;
    localparam int FN_OM_LSB = 3;
    localparam int FN_RST = 5;
    localparam int OTG_DP = 1;
    localparam int OTG_DM = 2;
    localparam int ST_RES_LSB = 0;
    localparam int ST_DIR = 4;
    localparam int ST_CLK = 5;
    localparam int RES_PU = 3;
    localparam int RES_DPD = 2;
    localparam int RES_DMD = 1;
    localparam int RES_TERM = 0;
    localparam logic [1:0] XS_RST = 2'h1;
    localparam logic TS_RST = 1'b0;
    localparam logic [1:0] OM_RST = 2'h0;
    localparam logic DP_RST = 1'b1;
    localparam logic DM_RST = 1'b1;
    localparam logic [1:0] OM_NODRIVE = 2'h1;
    localparam logic [3:0] RES_POWERUP = 4'h6;
    typedef enum logic [4:0] {
        ST_POR = 5'h01,
        ST_PLL = 5'h02,
        ST_IDLE = 5'h04,
        ST_RST = 5'h08,
        ST_RXCMD = 5'h10
    } utp_state_t;
endpackage

// ===== testbench/utp_core_tb.sv
// self-checking bench for the termination decode and power-up handshake
`timescale 1ns/1ns
module utp_core_tb
    import utp_pkg::*;
;
    logic clk_sys_i, reset_i, wb_cyc, wb_stb, wb_we, wb_ack_o, supply, pll;
    logic pu, dpd, dmd, term, dir_o, nxt_o, data_oe_o, clk_run_o, link_ready;
    logic [7:0] wb_adr, data_o, link_data, last_st;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_dat_o;
    logic [1:0] ls, xs, om;
    logic ts, dp, dm;
    logic [6:0] rows [3] = '{7'h0b, 7'h08, 7'h09};
    logic [31:0] rdq [$];
    int num_errors, tests_run, n;

    utp_core utp_core_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .core_supply_node_i(supply), .pll_locked_i(pll), .line_state_i(ls),
        .dp_pullup_enable_o(pu), .dp_weak_low_enable_o(dpd), .dm_weak_low_enable_o(dmd),
        .fast_termination_enable_o(term), .dir_o(dir_o), .nxt_o(nxt_o), .data_o(data_o),
        .data_oe_o(data_oe_o), .data_i(link_data), .clk_run_o(clk_run_o)
    );
    utp_link_model utp_link_model_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .dir_i(dir_o),
        .link_data_o(link_data), .ready_o(link_ready)
    );

    task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
        chk_pin("read data", e, s);
    endtask
    task automatic end_sim();
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // for reads d is the expected word, noted for the monitor
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= we ? d : 32'h0;
        if (!we) rdq.push_back(d);
        // look at ack mid-cycle, where it has settled, then release after the edge that sees it
        do begin
            @(negedge clk_sys_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) num_errors++;
        @(posedge clk_sys_i);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic wait_dir(input logic v, input int lim);
        int k;
        k = 0;
        while (dir_o !== v && k < lim) begin
            @(posedge clk_sys_i);
            k++;
        end
        if (dir_o !== v) num_errors++;
    endtask
    task automatic count_dir(output int c);
        c = 0;
        while (dir_o === 1'b1 && c < 1000) begin
            last_st = data_o;
            @(posedge clk_sys_i);
            c++;
        end
    endtask
    function automatic logic [3:0] res(input logic [1:0] x, input logic t, input logic [1:0] o,
        input logic p, input logic m);
        if (o == 2'h1) return 4'h0;
        return {t & ~p, p, m, (x == 2'h0) & ~t};
    endfunction

    always @(posedge clk_sys_i) begin
        if (wb_ack_o === 1'b1 && wb_we === 1'b0 && rdq.size() > 0) chk_rd(rdq.pop_front(), wb_dat_o);
    end
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // whole run is about 1500 cycles; ten thousand means a hang
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
    initial begin
        reset_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, pll, ls} = '0;
        wb_sel = 4'hf;
        supply = 1'b1;
        void'($urandom(32'h8fccfbc3));
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        chk_pin("enables", 32'(RES_POWERUP), {28'h0, pu, dpd, dmd, term});
        repeat (400) @(posedge clk_sys_i);
        chk_pin("dir nxt", 32'h2, {30'h0, dir_o, nxt_o});
        pll <= 1'b1;
        wait_dir(1'b0, 20);
        chk_pin("clk run oe", 32'h2, {30'h0, clk_run_o, data_oe_o});
        for (int i = 0; i < 200 && link_ready !== 1'b1; i++) @(posedge clk_sys_i);
        wb(1'b0, 8'h0c, 32'h0);
        for (int i = 0; i < 24; i++) begin
            {xs, ts, om, dp, dm} = (i < 3) ? rows[i] : 7'($urandom);
            ls <= 2'($urandom);
            wb(1'b1, ADR_OTG, {29'h0, dm, dp, 1'b0});
            wb(1'b1, ADR_FUNC, {27'h0, om, ts, xs});
            wb(1'b0, ADR_FUNC, {27'h0, om, ts, xs});
            wb(1'b0, ADR_STAT, {26'h0, 2'h2, res(xs, ts, om, dp, dm)});
            chk_pin("enables", {28'h0, res(xs, ts, om, dp, dm)}, {28'h0, pu, dpd, dmd, term});
        end
        // status bytes trusted only after this reset
        ls <= 2'($urandom);
        wb(1'b1, ADR_FUNC, 32'h20);
        wait_dir(1'b1, 10);
        count_dir(n);
        chk_pin("reset length", 32'(SRST_CYC) + 32'h1, n);
        chk_pin("status byte", {30'h0, ls}, {24'h0, last_st});
        wb(1'b0, ADR_FUNC, 32'h1);
        wb(1'b0, ADR_STAT, {26'h0, 2'h2, res(2'h1, 1'b0, 2'h0, 1'b1, 1'b1)});
        supply <= 1'b0;
        repeat (int'(LO_CYC) - 10) @(posedge clk_sys_i);
        supply <= 1'b1;
        n = 0;
        repeat (int'(HI_CYC) + int'(PORP_CYC) + 20) begin
            @(posedge clk_sys_i);
            if (dir_o === 1'b1) n++;
        end
        chk_pin("short dip", 32'h0, n);
        supply <= 1'b0;
        repeat (int'(LO_CYC) + 10) @(posedge clk_sys_i);
        supply <= 1'b1;
        wait_dir(1'b1, int'(HI_CYC) + 20);
        count_dir(n);
        chk_pin("pulse", 32'h1, 32'(n >= int'(PORP_CYC) && n <= int'(PORP_CYC) + 4));
        wb(1'b0, ADR_FUNC, 32'h1);
        wb(1'b0, ADR_OTG, 32'h6);
        end_sim();
    end
endmodule

// ===== testbench/utp_link_model.sv
// link-side model: idles the ulpi data bus and watches dir before resetting
`timescale 1ns/1ns
module utp_link_model #(
    parameter int WAIT_CYC = 50
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic dir_i,
    output logic [7:0] link_data_o,
    output logic ready_o
);
    int wait_q;
    logic [1:0] low_q;
    logic tog_q;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wait_q <= 0;
            low_q <= 2'h0;
            tog_q <= 1'b0;
        end else begin
            if (wait_q < WAIT_CYC) wait_q <= wait_q + 1;
            low_q <= dir_i ? 2'h0 : ((low_q == 2'h3) ? 2'h3 : low_q + 2'h1);
            tog_q <= ~tog_q;
        end
    end
    // zero idle; released bus toggles so stale values never look valid
    assign link_data_o = dir_i ? {8{tog_q}} : 8'h00;
    assign ready_o = (wait_q == WAIT_CYC) && (low_q == 2'h3);
endmodule
